// ---- sim/rkpc_top_checker.sv ----
// Concurrent checks on the ports of the radio key pairing controller.
// Assumes one clock, CLK_IN, and the active-high asynchronous reset SYS_RST_IN.
`timescale 1ns/1ns
module rkpc_top_checker (
  // Clock, reset, enable
  input  wire logic                        CLK_IN,
  input  wire logic                        SYS_RST_IN,
  input  wire logic                        CE_IN,
  // Strap and radio codes
  input  wire logic                        MODULE_VARIANT_IN,
  input  wire logic                        CODE_VALID_IN,
  input  wire logic [rkpc_pkg::CODE_W-1:0] CODE_IN,
  // Outputs
  input  wire logic                        LED_GREEN_OUT,
  input  wire logic                        LED_RED_OUT,
  input  wire logic                        OPEN_REQ_OUT,
  input  wire logic [rkpc_pkg::FUNC_W-1:0] OPEN_FUNC_OUT
);
  wire logic                        taken   = CODE_VALID_IN & CE_IN;
  wire logic [rkpc_pkg::FUNC_W-1:0] code_fn = CODE_IN[rkpc_pkg::FUNC_W-1:0];
  wire logic                        all_off = !LED_GREEN_OUT && !LED_RED_OUT && !OPEN_REQ_OUT;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  open_pulse_a: assert property (OPEN_REQ_OUT |=> !OPEN_REQ_OUT)
    else $error("open request stands longer than one cycle");
  open_cause_a: assert property (OPEN_REQ_OUT |-> $past(taken))
    else $error("open request without a taken code");
  open_func_a: assert property (OPEN_REQ_OUT |-> OPEN_FUNC_OUT == $past(code_fn))
    else $error("open function differs from the code");
  func_hold_a: assert property (!OPEN_REQ_OUT |-> $stable(OPEN_FUNC_OUT))
    else $error("open function moved without a request");
  open_idle_a: assert property (OPEN_REQ_OUT |-> !LED_GREEN_OUT && !LED_RED_OUT)
    else $error("open request while a procedure shows on the LEDs");
  red_ctrl_a: assert property (!MODULE_VARIANT_IN [*5] |-> !LED_RED_OUT)
    else $error("red LED lit on the control unit");
  reset_zero_a: assert property (disable iff (1'b0) SYS_RST_IN |-> all_off && OPEN_FUNC_OUT == 2'h0)
    else $error("outputs active during reset");
  release_quiet_a: assert property (disable iff (1'b0) $fell(SYS_RST_IN) |-> all_off)
    else $error("outputs active at reset release");

  cover property (OPEN_REQ_OUT);
  cover property ($rose(LED_RED_OUT));
  cover property ($rose(LED_GREEN_OUT));
endmodule : rkpc_top_checker

bind rkpc_top rkpc_top_checker u_rkpc_top_checker (
  .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .CE_IN(CE_IN), .MODULE_VARIANT_IN(MODULE_VARIANT_IN),
  .CODE_VALID_IN(CODE_VALID_IN), .CODE_IN(CODE_IN), .LED_GREEN_OUT(LED_GREEN_OUT),
  .LED_RED_OUT(LED_RED_OUT), .OPEN_REQ_OUT(OPEN_REQ_OUT), .OPEN_FUNC_OUT(OPEN_FUNC_OUT));

// ---- sim/rkpc_user.sv ----
// User side model: programming button and decoded radio key strobes.
// Assumes the bench calls its tasks; every change lands on a falling clock edge.
`timescale 1ns/1ns
module rkpc_user (
  // Clock
  input  wire logic                        clk_in,
  // Button and radio
  output logic                             btn_out,
  output logic                             valid_out,
  output logic [rkpc_pkg::CODE_W-1:0]      code_out
);
  initial begin
    btn_out = 1'b0;
    valid_out = 1'b0;
    code_out = 24'h000000;
  end

  // Holds the button for n cycles; the caller picks a short or a long hold.
  task automatic press(input int n);
    @(negedge clk_in);
    btn_out = 1'b1;
    repeat (n) @(negedge clk_in);
    btn_out = 1'b0;
  endtask : press

  // One strobe, sent well inside the window; afterwards the lines show the inverse, as a released receiver.
  task automatic send(input rkpc_pkg::rkpc_code_t c);
    @(negedge clk_in);
    valid_out = 1'b1;
    code_out = c;
    @(negedge clk_in);
    valid_out = 1'b0;
    code_out = ~c;
  endtask : send
endmodule : rkpc_user

// ---- sim/tb_rkpc_top.sv ----
// Self-checking bench for the radio key pairing controller with shortened timing parameters.
// Assumes the user model drives button and codes; clock enable stays high except for one strobe in sc_freeze.
`timescale 1ns/1ns
module tb_rkpc_top;
  localparam rkpc_pkg::rkpc_code_t MASTER = 24'h5A3C96; // Arbitrary value.
  localparam rkpc_pkg::rkpc_code_t KEY_A  = 24'h123455;
  localparam rkpc_pkg::rkpc_code_t KEY_B  = 24'h123456;
  localparam rkpc_pkg::rkpc_code_t KEY_C  = 24'h0ABCD3;
  localparam int unsigned SIM_SHORT = 10;
  localparam int unsigned SIM_LONG  = 30;
  localparam int unsigned SIM_WIN   = 200;
  localparam int unsigned SIM_ACK   = 20;
  localparam int unsigned SIM_OK_C  = 10;
  localparam int unsigned SIM_OK_M  = 40;
  localparam int unsigned SIM_SLOW  = 5;
  localparam int unsigned SIM_FAST  = 2;
  logic                 clk = 1'b0;
  logic                 rst;
  logic                 ce;
  logic                 variant;
  logic                 btn, vld, led_g, led_r, open_req;
  rkpc_pkg::rkpc_code_t code;
  rkpc_pkg::rkpc_func_t open_func;
  int                   mismatches = 0;
  int                   checked = 0;
  logic [7:0]           tg;
  logic                 lv;

  always #50 clk = ~clk;

  rkpc_top #(.MASTER_CODE(MASTER), .T_SHORT(SIM_SHORT), .T_LONG(SIM_LONG), .T_WIN(SIM_WIN), .T_ACK(SIM_ACK),
    .T_OK_CTRL(SIM_OK_C), .T_OK_MOD(SIM_OK_M), .T_SLOW(SIM_SLOW), .T_FAST(SIM_FAST)) u_rkpc_top (
    .CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(ce), .MODULE_VARIANT_IN(variant), .PROG_BTN_IN(btn),
    .CODE_VALID_IN(vld), .CODE_IN(code), .LED_GREEN_OUT(led_g), .LED_RED_OUT(led_r),
    .OPEN_REQ_OUT(open_req), .OPEN_FUNC_OUT(open_func));
  rkpc_user u_rkpc_user (.clk_in(clk), .btn_out(btn), .valid_out(vld), .code_out(code));

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  task automatic check_bit(input logic got, input logic exp, input string msg);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask : check_bit

  task automatic check_vec(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check_vec

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  // Counts LED changes over n cycles and returns the last level.
  task automatic watch(input bit red, input int n, output logic [7:0] t, output logic l);
    logic prev;
    t = 8'h00;
    @(negedge clk);
    prev = red ? led_r : led_g;
    l = prev;
    repeat (n) begin
      @(negedge clk);
      l = red ? led_r : led_g;
      if (l !== prev) t = t + 8'h01;
      prev = l;
    end
  endtask : watch

  task automatic expect_open(input rkpc_pkg::rkpc_code_t c, input logic exp);
    u_rkpc_user.send(c);
    check_bit(open_req, exp, "open request");
    if (exp) check_vec({6'h00, open_func}, {6'h00, c[1:0]}, "open function");
  endtask : expect_open

  task automatic tune(input rkpc_pkg::rkpc_code_t c, input bit chk);
    u_rkpc_user.press(5);
    wt(10);
    if (chk) begin
      watch(1'b0, 20, tg, lv);
      check_vec(tg, 8'h04, "slow flash");
    end
    u_rkpc_user.send(MASTER);
    if (chk) begin
      watch(1'b0, 15, tg, lv);
      check_vec(tg, 8'h00, "tune ack steady");
      check_bit(lv, 1'b1, "tune ack green");
    end
    wt(25);
    u_rkpc_user.send(c);
    u_rkpc_user.send(c);
    if (chk) begin
      watch(1'b0, 6, tg, lv);
      check_vec(tg, 8'h00, "stored steady");
      check_bit(lv, 1'b1, "stored green");
    end
    wt(15);
  endtask : tune

  task automatic del_mode(input bit red);
    u_rkpc_user.press(40);
    wt(5);
    watch(red, 20, tg, lv);
    check_vec(tg, 8'h0A, "fast flash");
    u_rkpc_user.send(MASTER);
    watch(1'b0, 15, tg, lv);
    check_vec(tg, 8'h00, "delete ack steady");
    check_bit(lv, 1'b1, "delete ack green");
  endtask : del_mode

  task automatic sc_first_erase();
    del_mode(1'b0);
    u_rkpc_user.press(40);
    wt(25);
    expect_open(MASTER, 1'b1);
    expect_open(KEY_A, 1'b0);
  endtask : sc_first_erase

  task automatic sc_tune();
    tune(KEY_A, 1'b1);
    tune(KEY_B, 1'b0);
    expect_open(KEY_A, 1'b1);
    expect_open(KEY_B, 1'b1);
  endtask : sc_tune

  task automatic sc_abort_timeout();
    u_rkpc_user.press(5);
    wt(10);
    expect_open(KEY_B, 1'b0);
    wt(2);
    expect_open(KEY_B, 1'b1);
    u_rkpc_user.press(5);
    wt(10);
    u_rkpc_user.send(MASTER);
    wt(220);
    expect_open(KEY_C, 1'b0);
    expect_open(KEY_C, 1'b0);
    wt(15);
    expect_open(KEY_C, 1'b0);
  endtask : sc_abort_timeout

  task automatic sc_delete_one();
    del_mode(1'b0);
    wt(25);
    u_rkpc_user.send(KEY_A);
    watch(1'b0, 6, tg, lv);
    check_vec(tg, 8'h00, "deleted steady");
    check_bit(lv, 1'b1, "deleted green");
    wt(15);
    expect_open(KEY_A, 1'b0);
    expect_open(KEY_B, 1'b1);
  endtask : sc_delete_one

  // With the clock enable low a strobe must not be taken; afterwards the same code opens.
  task automatic sc_freeze();
    @(negedge clk);
    ce = 1'b0;
    expect_open(KEY_B, 1'b0);
    @(negedge clk);
    ce = 1'b1;
    expect_open(KEY_B, 1'b1);
  endtask : sc_freeze

  task automatic sc_full();
    for (int i = 0; i < 24; i++) tune(rkpc_pkg::rkpc_code_t'(24'h100000 + i), 1'b0);
    tune(KEY_C, 1'b0);
    expect_open(KEY_C, 1'b0);
    expect_open(KEY_B, 1'b1);
    for (int i = 0; i < 24; i++) expect_open(rkpc_pkg::rkpc_code_t'(24'h100000 + i), 1'b1);
  endtask : sc_full

  task automatic sc_module_erase();
    variant = 1'b1;
    wt(5);
    del_mode(1'b1);
    u_rkpc_user.press(40);
    watch(1'b1, 20, tg, lv);
    check_vec(tg, 8'h00, "erase red steady");
    check_bit(lv, 1'b1, "erase red lit");
    check_bit(led_g, 1'b0, "erase green dark");
    wt(30);
    expect_open(KEY_B, 1'b0);
    expect_open(MASTER, 1'b1);
  endtask : sc_module_erase

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    variant = 1'b0;
    wt(10);
    rst = 1'b0;
    wt(2);
    sc_first_erase();
    sc_tune();
    sc_abort_timeout();
    sc_delete_one();
    sc_freeze();
    sc_full();
    sc_module_erase();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : tb_rkpc_top

// ---- src/rkpc_btn.sv ----
// Programming button classifier: synchroniser, hold timer, press events.
// Assumes the raw button is asynchronous and active high while pressed.
`timescale 1ns/1ns
module rkpc_btn #(
  parameter int unsigned T_SHORT = rkpc_pkg::SHORT_MS * rkpc_pkg::CYC_PER_MS,
  parameter int unsigned T_LONG  = rkpc_pkg::LONG_MS * rkpc_pkg::CYC_PER_MS
) (
  // Clock, reset, enable
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   ce,
  // Raw button
  input  wire logic   btn_raw,
  // Events
  rkpc_btn_if.src     ev
);

  logic               s1_r, s2_r;
  rkpc_pkg::rkpc_tmr_t cnt_r, cnt_nxt;
  logic               short_r, short_nxt;
  logic               long_r, long_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // The counter saturates at the long threshold so the long event fires once per hold.
  always_comb begin
    cnt_nxt   = cnt_r;
    short_nxt = 1'b0;
    long_nxt  = 1'b0;
    if (s2_r) begin
      if (cnt_r != rkpc_pkg::rkpc_tmr_t'(T_LONG)) begin
        cnt_nxt = cnt_r + rkpc_pkg::TMR_ONE;
      end
      long_nxt = (cnt_r == rkpc_pkg::rkpc_tmr_t'(T_LONG - 1));
    end else if (cnt_r != rkpc_pkg::TMR_ZERO) begin
      short_nxt = (cnt_r <= rkpc_pkg::rkpc_tmr_t'(T_SHORT));
      cnt_nxt   = rkpc_pkg::TMR_ZERO;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      cnt_r   <= rkpc_pkg::TMR_ZERO;
      short_r <= 1'b0;
      long_r  <= 1'b0;
    end else if (ce) begin
      s1_r    <= btn_raw;
      s2_r    <= s1_r;
      cnt_r   <= cnt_nxt;
      short_r <= short_nxt;
      long_r  <= long_nxt;
    end
  end

  assign ev.short_p = short_r;
  assign ev.long_p  = long_r;

endmodule : rkpc_btn

// ---- src/rkpc_btn_if.sv ----
// Press events from the button classifier to the procedure controller.
// Both ends run on the same clock; events are one-cycle pulses.
`timescale 1ns/1ns
interface rkpc_btn_if;
  logic short_p;
  logic long_p;
  modport src (output short_p, output long_p);
  modport dst (input short_p, input long_p);
endinterface : rkpc_btn_if

// ---- src/rkpc_pkg.sv ----
// Constants, timing figures and types for the radio key pairing controller.
// Assumes a single 10 MHz clock; long counts become top-level parameters.
package rkpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock in hertz and timing figures in milliseconds.
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned SHORT_MS   = 1000;
  localparam int unsigned LONG_MS    = 3000;
  localparam int unsigned WIN_MS     = 20000;
  localparam int unsigned ACK_MS     = 2000;
  localparam int unsigned OK_CTRL_MS = 1000;
  localparam int unsigned OK_MOD_MS  = 4000;
  localparam int unsigned SLOW_MS    = 500;
  localparam int unsigned FAST_MS    = 125;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and table layout.
  localparam int TMR_W    = 28;
  localparam int NUM_USER = 25;
  localparam int IDX_W    = 5;
  localparam int CODE_W   = 24;
  localparam int FUNC_W   = 2;
  localparam int FUNC_LSB = 0;

  typedef logic [TMR_W-1:0]  rkpc_tmr_t;
  typedef logic [CODE_W-1:0] rkpc_code_t;
  typedef logic [IDX_W-1:0]  rkpc_idx_t;
  typedef logic [FUNC_W-1:0] rkpc_func_t;

  localparam rkpc_tmr_t  TMR_ZERO  = 28'h0000000;
  localparam rkpc_tmr_t  TMR_ONE   = 28'h0000001;
  localparam rkpc_code_t CODE_ZERO = 24'h000000;
  localparam rkpc_func_t FUNC_ZERO = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Procedure states.
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_T_MST = 6'h02,
    ST_T_KEY = 6'h04,
    ST_D_MST = 6'h08,
    ST_D_SEL = 6'h10,
    ST_DONE  = 6'h20
  } rkpc_state_e;

endpackage : rkpc_pkg

// ---- src/rkpc_top.sv ----
// Radio key pairing controller: user key table, tune-in and delete procedures, LEDs.
// Assumes decoded radio codes arrive as one-cycle strobes from logic on CLK_IN.
`timescale 1ns/1ns
module rkpc_top #(
  parameter rkpc_pkg::rkpc_code_t MASTER_CODE = 24'h5A3C96, // Arbitrary value.
  parameter int unsigned T_SHORT   = rkpc_pkg::SHORT_MS * rkpc_pkg::CYC_PER_MS,
  parameter int unsigned T_LONG    = rkpc_pkg::LONG_MS * rkpc_pkg::CYC_PER_MS,
  parameter int unsigned T_WIN     = rkpc_pkg::WIN_MS * rkpc_pkg::CYC_PER_MS,
  parameter int unsigned T_ACK     = rkpc_pkg::ACK_MS * rkpc_pkg::CYC_PER_MS,
  parameter int unsigned T_OK_CTRL = rkpc_pkg::OK_CTRL_MS * rkpc_pkg::CYC_PER_MS,
  parameter int unsigned T_OK_MOD  = rkpc_pkg::OK_MOD_MS * rkpc_pkg::CYC_PER_MS,
  parameter int unsigned T_SLOW    = rkpc_pkg::SLOW_MS * rkpc_pkg::CYC_PER_MS,
  parameter int unsigned T_FAST    = rkpc_pkg::FAST_MS * rkpc_pkg::CYC_PER_MS
) (
  // Clock, reset, enable
  input  wire logic                          CLK_IN,
  input  wire logic                          SYS_RST_IN,
  input  wire logic                          CE_IN,
  // Board straps and button
  input  wire logic                          MODULE_VARIANT_IN,
  input  wire logic                          PROG_BTN_IN,
  // Decoded radio codes
  input  wire logic                          CODE_VALID_IN,
  input  wire logic [rkpc_pkg::CODE_W-1:0]   CODE_IN,
  // Indicators and door request
  output logic                               LED_GREEN_OUT,
  output logic                               LED_RED_OUT,
  output logic                               OPEN_REQ_OUT,
  output logic [rkpc_pkg::FUNC_W-1:0]        OPEN_FUNC_OUT
);

  rkpc_btn_if btn ();

  rkpc_btn #(.T_SHORT(T_SHORT), .T_LONG(T_LONG)) u_btn (
    .clk     (CLK_IN),
    .rst     (SYS_RST_IN),
    .ce      (CE_IN),
    .btn_raw (PROG_BTN_IN),
    .ev      (btn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Table lookup helpers.
  function automatic rkpc_pkg::rkpc_idx_t first_set(input logic [rkpc_pkg::NUM_USER-1:0] v);
    rkpc_pkg::rkpc_idx_t idx;
    idx = '0;
    for (int i = rkpc_pkg::NUM_USER - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = rkpc_pkg::rkpc_idx_t'(i);
      end
    end
    return idx;
  endfunction : first_set

  rkpc_pkg::rkpc_state_e  st_r, st_nxt;
  rkpc_pkg::rkpc_code_t   code_r [rkpc_pkg::NUM_USER];
  rkpc_pkg::rkpc_code_t   code_nxt [rkpc_pkg::NUM_USER];
  logic [rkpc_pkg::NUM_USER-1:0] val_r, val_nxt;
  logic [rkpc_pkg::NUM_USER-1:0] hit, free;
  rkpc_pkg::rkpc_tmr_t    win_r, win_nxt;
  rkpc_pkg::rkpc_tmr_t    ack_r, ack_nxt;
  rkpc_pkg::rkpc_tmr_t    hold_r, hold_nxt;
  rkpc_pkg::rkpc_tmr_t    blk_r, blk_nxt;
  rkpc_pkg::rkpc_code_t   first_r, first_nxt;
  logic                   first_v_r, first_v_nxt;
  logic                   done_red_r, done_red_nxt;
  logic                   phase_r, phase_nxt;
  logic                   var_s1_r, var_s2_r;
  logic                   led_g_r, led_g_nxt;
  logic                   led_r_r, led_r_nxt;
  logic                   open_r, open_nxt;
  rkpc_pkg::rkpc_func_t   func_r, func_nxt;
  logic                   is_master;

  genvar gi;
  generate
    for (gi = 0; gi < rkpc_pkg::NUM_USER; gi++) begin : g_match
      assign hit[gi]  = val_r[gi] && (code_r[gi] == CODE_IN);
      assign free[gi] = !val_r[gi];
    end
  endgenerate

  assign is_master = (CODE_IN == MASTER_CODE);

  ////////////////////////////////////////////////////////////////////////////
  // Procedure sequencer and code table.
  always_comb begin
    st_nxt       = st_r;
    code_nxt     = code_r;
    val_nxt      = val_r;
    first_nxt    = first_r;
    first_v_nxt  = first_v_r;
    done_red_nxt = done_red_r;
    open_nxt     = 1'b0;
    func_nxt     = func_r;
    win_nxt      = (win_r == rkpc_pkg::TMR_ZERO) ? win_r : win_r - rkpc_pkg::TMR_ONE;
    ack_nxt      = (ack_r == rkpc_pkg::TMR_ZERO) ? ack_r : ack_r - rkpc_pkg::TMR_ONE;
    hold_nxt     = (hold_r == rkpc_pkg::TMR_ZERO) ? hold_r : hold_r - rkpc_pkg::TMR_ONE;
    case (st_r)
      rkpc_pkg::ST_IDLE: begin
        if (btn.long_p) begin
          st_nxt  = rkpc_pkg::ST_D_MST;
          win_nxt = rkpc_pkg::rkpc_tmr_t'(T_WIN);
        end else if (btn.short_p) begin
          st_nxt  = rkpc_pkg::ST_T_MST;
          win_nxt = rkpc_pkg::rkpc_tmr_t'(T_WIN);
        end else if (CODE_VALID_IN && (is_master || (|hit))) begin
          open_nxt = 1'b1;
          func_nxt = CODE_IN[rkpc_pkg::FUNC_LSB +: rkpc_pkg::FUNC_W];
        end
      end
      rkpc_pkg::ST_T_MST, rkpc_pkg::ST_D_MST: begin
        if (CODE_VALID_IN) begin
          if (is_master) begin
            st_nxt      = (st_r == rkpc_pkg::ST_T_MST) ? rkpc_pkg::ST_T_KEY : rkpc_pkg::ST_D_SEL;
            win_nxt     = rkpc_pkg::rkpc_tmr_t'(T_WIN);
            ack_nxt     = rkpc_pkg::rkpc_tmr_t'(T_ACK);
            first_v_nxt = 1'b0;
          end else begin
            st_nxt = rkpc_pkg::ST_IDLE;
          end
        end else if (win_r == rkpc_pkg::TMR_ZERO) begin
          st_nxt = rkpc_pkg::ST_IDLE;
        end
      end
      rkpc_pkg::ST_T_KEY: begin
        if (CODE_VALID_IN && !is_master) begin
          if (first_v_r && (CODE_IN == first_r)) begin
            if ((|hit) || (|free)) begin
              if (!(|hit)) begin
                code_nxt[first_set(free)] = CODE_IN;
                val_nxt[first_set(free)]  = 1'b1;
              end
              st_nxt       = rkpc_pkg::ST_DONE;
              done_red_nxt = var_s2_r;
              hold_nxt     = var_s2_r ? rkpc_pkg::rkpc_tmr_t'(T_OK_MOD) : rkpc_pkg::rkpc_tmr_t'(T_OK_CTRL);
            end else begin
              st_nxt = rkpc_pkg::ST_IDLE;
            end
          end else begin
            first_nxt   = CODE_IN;
            first_v_nxt = 1'b1;
          end
        end else if (win_r == rkpc_pkg::TMR_ZERO) begin
          st_nxt = rkpc_pkg::ST_IDLE;
        end
      end
      rkpc_pkg::ST_D_SEL: begin
        if (btn.long_p) begin
          val_nxt      = '0;
          st_nxt       = rkpc_pkg::ST_DONE;
          done_red_nxt = var_s2_r;
          hold_nxt     = var_s2_r ? rkpc_pkg::rkpc_tmr_t'(T_OK_MOD) : rkpc_pkg::rkpc_tmr_t'(T_OK_CTRL);
        end else if (CODE_VALID_IN && !is_master) begin
          if (|hit) begin
            val_nxt[first_set(hit)] = 1'b0;
            st_nxt       = rkpc_pkg::ST_DONE;
            done_red_nxt = 1'b0;
            hold_nxt     = rkpc_pkg::rkpc_tmr_t'(T_OK_CTRL);
          end else begin
            st_nxt = rkpc_pkg::ST_IDLE;
          end
        end else if (win_r == rkpc_pkg::TMR_ZERO) begin
          st_nxt = rkpc_pkg::ST_IDLE;
        end
      end
      rkpc_pkg::ST_DONE: begin
        if (hold_r == rkpc_pkg::TMR_ZERO) begin
          st_nxt = rkpc_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = rkpc_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator pattern: solid acknowledge overrides the mode flash.
  always_comb begin
    blk_nxt   = blk_r - rkpc_pkg::TMR_ONE;
    phase_nxt = phase_r;
    if (blk_r == rkpc_pkg::TMR_ZERO) begin
      phase_nxt = !phase_r;
      blk_nxt   = ((st_r == rkpc_pkg::ST_D_MST) || (st_r == rkpc_pkg::ST_D_SEL))
                  ? rkpc_pkg::rkpc_tmr_t'(T_FAST - 1) : rkpc_pkg::rkpc_tmr_t'(T_SLOW - 1);
    end
    led_g_nxt = 1'b0;
    led_r_nxt = 1'b0;
    case (st_r)
      rkpc_pkg::ST_T_MST, rkpc_pkg::ST_T_KEY, rkpc_pkg::ST_D_MST, rkpc_pkg::ST_D_SEL: begin
        if (ack_r != rkpc_pkg::TMR_ZERO && (st_r == rkpc_pkg::ST_T_KEY || st_r == rkpc_pkg::ST_D_SEL)) begin
          led_g_nxt = 1'b1;
        end else begin
          led_g_nxt = phase_r && !var_s2_r;
          led_r_nxt = phase_r && var_s2_r;
        end
      end
      rkpc_pkg::ST_DONE: begin
        led_g_nxt = !done_red_r;
        led_r_nxt = done_red_r;
      end
      default: begin
        led_g_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_r       <= rkpc_pkg::ST_IDLE;
      code_r     <= '{default: rkpc_pkg::CODE_ZERO};
      val_r      <= '0;
      win_r      <= rkpc_pkg::TMR_ZERO;
      ack_r      <= rkpc_pkg::TMR_ZERO;
      hold_r     <= rkpc_pkg::TMR_ZERO;
      blk_r      <= rkpc_pkg::TMR_ZERO;
      first_r    <= rkpc_pkg::CODE_ZERO;
      first_v_r  <= 1'b0;
      done_red_r <= 1'b0;
      phase_r    <= 1'b0;
      var_s1_r   <= 1'b0;
      var_s2_r   <= 1'b0;
      led_g_r    <= 1'b0;
      led_r_r    <= 1'b0;
      open_r     <= 1'b0;
      func_r     <= rkpc_pkg::FUNC_ZERO;
    end else if (CE_IN) begin
      st_r       <= st_nxt;
      code_r     <= code_nxt;
      val_r      <= val_nxt;
      win_r      <= win_nxt;
      ack_r      <= ack_nxt;
      hold_r     <= hold_nxt;
      blk_r      <= blk_nxt;
      first_r    <= first_nxt;
      first_v_r  <= first_v_nxt;
      done_red_r <= done_red_nxt;
      phase_r    <= phase_nxt;
      var_s1_r   <= MODULE_VARIANT_IN;
      var_s2_r   <= var_s1_r;
      led_g_r    <= led_g_nxt;
      led_r_r    <= led_r_nxt;
      open_r     <= open_nxt;
      func_r     <= func_nxt;
    end
  end

  assign LED_GREEN_OUT = led_g_r;
  assign LED_RED_OUT   = led_r_r;
  assign OPEN_REQ_OUT  = open_r;
  assign OPEN_FUNC_OUT = func_r;

endmodule : rkpc_top
